// ### design/pbcg_pkg.sv
// constants, register map and state types of the peripheral bus clock gates
// assumes a 32-bit apb slave port with 12-bit byte addresses
package pbcg_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 8;

	// register byte addresses
	localparam logic [ADDR_W-1:0] PORT_GATES_OFS   = 12'h000;
	localparam logic [ADDR_W-1:0] MISC_GATES_OFS   = 12'h004;
	localparam logic [ADDR_W-1:0] ANALOG_GATES_OFS = 12'h008;

	// implemented bits; every implemented gate comes up passing the clock
	localparam logic [REG_W-1:0] PORT_GATES_MASK   = 8'hFF;
	localparam logic [REG_W-1:0] MISC_GATES_MASK   = 8'h7F;
	localparam logic [REG_W-1:0] ANALOG_GATES_MASK = 8'hFD;
	localparam logic [REG_W-1:0] PORT_GATES_RST    = PORT_GATES_MASK;
	localparam logic [REG_W-1:0] MISC_GATES_RST    = MISC_GATES_MASK;
	localparam logic [REG_W-1:0] ANALOG_GATES_RST  = ANALOG_GATES_MASK;

	// port_clock_gates fields
	localparam int unsigned PORT_H_BIT = 7;
	localparam int unsigned PORT_G_BIT = 6;
	localparam int unsigned PORT_F_BIT = 5;
	localparam int unsigned PORT_E_BIT = 4;
	localparam int unsigned PORT_D_BIT = 3;
	localparam int unsigned PORT_C_BIT = 2;
	localparam int unsigned PORT_B_BIT = 1;
	localparam int unsigned PORT_A_BIT = 0;

	// misc_peripheral_clock_gates fields
	localparam int unsigned PIN_SELECT_BIT  = 6;
	localparam int unsigned CHECKSUM_BIT    = 5;
	localparam int unsigned FLEX_TIMER_BIT  = 4;
	localparam int unsigned DELAY_BLOCK_BIT = 3;
	localparam int unsigned MOD_TIMER1_BIT  = 2;
	localparam int unsigned MOD_TIMER2_BIT  = 1;
	localparam int unsigned MOD_TIMER3_BIT  = 0;

	// analog_system_clock_gates fields
	localparam int unsigned CMP_TWO_BIT    = 7;
	localparam int unsigned CMP_ONE_BIT    = 6;
	localparam int unsigned CMP_ZERO_BIT   = 5;
	localparam int unsigned BREAKPOINT_BIT = 4;
	localparam int unsigned RTC_BIT        = 3;
	localparam int unsigned PULSE_CNT_BIT  = 2;
	localparam int unsigned FLASH_BIT      = 0;

	// position of each register inside the flat gate vector
	localparam int unsigned PORT_BASE   = 0;
	localparam int unsigned MISC_BASE   = 8;
	localparam int unsigned ANALOG_BASE = 16;
	localparam int unsigned GATE_NUM    = 24;

	typedef enum logic [1:0] {SEL_NONE, SEL_PORT, SEL_MISC, SEL_ANALOG} pbcg_sel_t;

	typedef struct packed {
		logic [REG_W-1:0]  port_q;
		logic [REG_W-1:0]  misc_q;
		logic [REG_W-1:0]  analog_q;
		logic [DATA_W-1:0] rdata_q;
		logic              slverr_q;
	} pbcg_state_t;

	typedef struct packed {
		logic on_q;
	} pbcg_cell_state_t;

endpackage

// ### design/pbcg_clock_gate.sv
// one glitch-free bus clock gate
// assumes en changes only just after a rising edge of clk
`timescale 1ns/10ps

module pbcg_clock_gate #(
	parameter logic RESET_ON = 1'b1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic en,
	// gated clock and gate state
	output logic      gclk,
	output logic      gate_on
);

	pbcg_pkg::pbcg_cell_state_t s_q;
	pbcg_pkg::pbcg_cell_state_t s_d;

	always_comb
	begin
		s_d.on_q = en;
	end

	// enable caught on the falling edge of clk, so a change never cuts a high phase short
	always_ff @(negedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '{on_q: RESET_ON};
		else
			s_q <= s_d;
	end

	assign gclk    = clk & s_q.on_q;
	assign gate_on = s_q.on_q;

endmodule

// ### design/pbcg_top.sv
// apb register block and clock gates for the on-chip peripherals
// assumes software quiets a peripheral before stopping its clock
`timescale 1ns/10ps

module pbcg_top (
	// clock and reset
	input  wire logic                          SYS_CLK,
	input  wire logic                          RESET_N,
	// apb slave
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [pbcg_pkg::ADDR_W-1:0]   PADDR,
	input  wire logic [pbcg_pkg::DATA_W-1:0]   PWDATA,
	input  wire logic [3:0]                    PSTRB,
	output logic      [pbcg_pkg::DATA_W-1:0]   PRDATA,
	output logic                               PREADY,
	output logic                               PSLVERR,
	// gated port clocks
	output logic                               PORT_A_CLK,
	output logic                               PORT_B_CLK,
	output logic                               PORT_C_CLK,
	output logic                               PORT_D_CLK,
	output logic                               PORT_E0_CLK,
	output logic                               PORT_E1_CLK,
	output logic                               PORT_F_CLK,
	output logic                               PORT_G_CLK,
	output logic                               PORT_H_CLK,
	// gated misc peripheral clocks
	output logic                               PIN_SELECT_CLK,
	output logic                               CHECKSUM_CLK,
	output logic                               FLEX_TIMER_CLK,
	output logic                               DELAY_BLOCK_CLK,
	output logic                               MOD_TIMER_ONE_CLK,
	output logic                               MOD_TIMER_TWO_CLK,
	output logic                               MOD_TIMER_THREE_CLK,
	// gated analog and system clocks
	output logic                               CMP_TWO_CLK,
	output logic                               CMP_ONE_CLK,
	output logic                               CMP_ZERO_CLK,
	output logic                               BREAKPOINT_CLK,
	output logic                               RTC_CLK,
	output logic                               PULSE_COUNTER_CLK,
	output logic                               FLASH_CLK,
	// gate state as seen by the peripherals
	output logic      [pbcg_pkg::GATE_NUM-1:0] GATE_ON
);

	localparam logic [pbcg_pkg::GATE_NUM-1:0] IMPL_MASK = {
		pbcg_pkg::ANALOG_GATES_MASK, pbcg_pkg::MISC_GATES_MASK, pbcg_pkg::PORT_GATES_MASK};

	pbcg_pkg::pbcg_state_t s_q;
	pbcg_pkg::pbcg_state_t s_d;

	pbcg_pkg::pbcg_sel_t               sel;
	logic                              setup_ph;
	logic                              access_ph;
	logic                              wr_en;
	logic [pbcg_pkg::GATE_NUM-1:0]     gate_en;
	logic [pbcg_pkg::GATE_NUM-1:0]     gclk;

	function automatic pbcg_pkg::pbcg_sel_t decode_sel(input logic [pbcg_pkg::ADDR_W-1:0] addr);
		if (addr == pbcg_pkg::PORT_GATES_OFS)
			return pbcg_pkg::SEL_PORT;
		else if (addr == pbcg_pkg::MISC_GATES_OFS)
			return pbcg_pkg::SEL_MISC;
		else if (addr == pbcg_pkg::ANALOG_GATES_OFS)
			return pbcg_pkg::SEL_ANALOG;
		else
			return pbcg_pkg::SEL_NONE;
	endfunction

	// unused positions are masked so they stay 0 whatever is written
	function automatic logic [pbcg_pkg::REG_W-1:0] masked(
		input logic [pbcg_pkg::DATA_W-1:0] wdata,
		input logic [pbcg_pkg::REG_W-1:0]  mask);
		return wdata[pbcg_pkg::REG_W-1:0] & mask;
	endfunction

	function automatic logic [pbcg_pkg::DATA_W-1:0] widen(input logic [pbcg_pkg::REG_W-1:0] r);
		return {24'h00_0000, r};
	endfunction

	assign sel       = decode_sel(PADDR);
	assign setup_ph  = PSEL & ~PENABLE;
	assign access_ph = PSEL & PENABLE;
	// only the low byte lane holds register bits; other lanes alone change nothing
	assign wr_en     = access_ph & PWRITE & PSTRB[0];

	always_comb
	begin
		s_d = s_q;
		// read data and error are settled in the setup cycle, so they leave a flop
		if (setup_ph)
		begin
			s_d.slverr_q = (sel == pbcg_pkg::SEL_NONE);
			s_d.rdata_q  = 32'h0000_0000;
			if (!PWRITE)
			begin
				case (sel)
					pbcg_pkg::SEL_PORT:   s_d.rdata_q = widen(s_q.port_q);
					pbcg_pkg::SEL_MISC:   s_d.rdata_q = widen(s_q.misc_q);
					pbcg_pkg::SEL_ANALOG: s_d.rdata_q = widen(s_q.analog_q);
					default:              s_d.rdata_q = 32'h0000_0000;
				endcase
			end
		end
		if (wr_en)
		begin
			case (sel)
				pbcg_pkg::SEL_PORT:
					s_d.port_q = masked(PWDATA, pbcg_pkg::PORT_GATES_MASK);
				pbcg_pkg::SEL_MISC:
					s_d.misc_q = masked(PWDATA, pbcg_pkg::MISC_GATES_MASK);
				pbcg_pkg::SEL_ANALOG:
					s_d.analog_q = masked(PWDATA, pbcg_pkg::ANALOG_GATES_MASK);
				default:
					s_d.port_q = s_q.port_q;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			s_q.port_q   <= pbcg_pkg::PORT_GATES_RST;
			s_q.misc_q   <= pbcg_pkg::MISC_GATES_RST;
			s_q.analog_q <= pbcg_pkg::ANALOG_GATES_RST;
			s_q.rdata_q  <= 32'h0000_0000;
			s_q.slverr_q <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// one wait-free access phase; the setup cycle already fixed the answer
	assign PREADY  = access_ph;
	assign PRDATA  = s_q.rdata_q;
	assign PSLVERR = access_ph & s_q.slverr_q;

	assign gate_en = {s_q.analog_q, s_q.misc_q, s_q.port_q};

	// the bus clock itself is switched, not an enable, so idle peripherals draw no current
	genvar gi;
	generate
		for (gi = 0; gi < pbcg_pkg::GATE_NUM; gi++)
		begin : g_gate
			if (IMPL_MASK[gi])
			begin : g_cell
				pbcg_clock_gate #(
					.RESET_ON (1'b1)
				) u_gate (
					.clk     (SYS_CLK),
					.rst_n   (RESET_N),
					.en      (gate_en[gi]),
					.gclk    (gclk[gi]),
					.gate_on (GATE_ON[gi])
				);
			end
			else
			begin : g_none
				assign gclk[gi]    = 1'b0;
				assign GATE_ON[gi] = 1'b0;
			end
		end
	endgenerate

	assign PORT_H_CLK          = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_H_BIT];
	assign PORT_G_CLK          = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_G_BIT];
	assign PORT_F_CLK          = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_F_BIT];
	// both port e modules share one gate so they can never disagree
	assign PORT_E0_CLK         = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_E_BIT];
	assign PORT_E1_CLK         = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_E_BIT];
	assign PORT_D_CLK          = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_D_BIT];
	assign PORT_C_CLK          = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_C_BIT];
	assign PORT_B_CLK          = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_B_BIT];
	assign PORT_A_CLK          = gclk[pbcg_pkg::PORT_BASE + pbcg_pkg::PORT_A_BIT];
	assign PIN_SELECT_CLK      = gclk[pbcg_pkg::MISC_BASE + pbcg_pkg::PIN_SELECT_BIT];
	assign CHECKSUM_CLK        = gclk[pbcg_pkg::MISC_BASE + pbcg_pkg::CHECKSUM_BIT];
	assign FLEX_TIMER_CLK      = gclk[pbcg_pkg::MISC_BASE + pbcg_pkg::FLEX_TIMER_BIT];
	assign DELAY_BLOCK_CLK     = gclk[pbcg_pkg::MISC_BASE + pbcg_pkg::DELAY_BLOCK_BIT];
	assign MOD_TIMER_ONE_CLK   = gclk[pbcg_pkg::MISC_BASE + pbcg_pkg::MOD_TIMER1_BIT];
	assign MOD_TIMER_TWO_CLK   = gclk[pbcg_pkg::MISC_BASE + pbcg_pkg::MOD_TIMER2_BIT];
	assign MOD_TIMER_THREE_CLK = gclk[pbcg_pkg::MISC_BASE + pbcg_pkg::MOD_TIMER3_BIT];
	assign CMP_TWO_CLK         = gclk[pbcg_pkg::ANALOG_BASE + pbcg_pkg::CMP_TWO_BIT];
	assign CMP_ONE_CLK         = gclk[pbcg_pkg::ANALOG_BASE + pbcg_pkg::CMP_ONE_BIT];
	assign CMP_ZERO_CLK        = gclk[pbcg_pkg::ANALOG_BASE + pbcg_pkg::CMP_ZERO_BIT];
	assign BREAKPOINT_CLK      = gclk[pbcg_pkg::ANALOG_BASE + pbcg_pkg::BREAKPOINT_BIT];
	assign RTC_CLK             = gclk[pbcg_pkg::ANALOG_BASE + pbcg_pkg::RTC_BIT];
	assign PULSE_COUNTER_CLK   = gclk[pbcg_pkg::ANALOG_BASE + pbcg_pkg::PULSE_CNT_BIT];
	assign FLASH_CLK           = gclk[pbcg_pkg::ANALOG_BASE + pbcg_pkg::FLASH_BIT];

	// checks: a write reaches the gate state one edge after the access edge
	logic wr_port;
	logic wr_misc;
	logic wr_analog;

	assign wr_port   = wr_en & (sel == pbcg_pkg::SEL_PORT);
	assign wr_misc   = wr_en & (sel == pbcg_pkg::SEL_MISC);
	assign wr_analog = wr_en & (sel == pbcg_pkg::SEL_ANALOG);

	a_port_high_gates:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_port |=> GATE_ON[7:5] == $past(PWDATA[7:5]))
	else $error("port h g f gates do not follow the written bits");

	a_port_e_pair:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_port && !PWDATA[pbcg_pkg::PORT_E_BIT]
		|=> !GATE_ON[pbcg_pkg::PORT_E_BIT] && !PORT_E0_CLK && !PORT_E1_CLK)
	else $error("port e modules still clocked after their gate was cleared");

	a_port_low_gates:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_port ##1 !wr_port |-> ##1 GATE_ON[3:0] == $past(PWDATA[3:0], 2))
	else $error("port d c b a gates lost the written value");

	a_pin_select_gate:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_misc |=> GATE_ON[pbcg_pkg::MISC_BASE + 6] == $past(PWDATA[6]))
	else $error("pin select gate does not follow bit 6");

	a_checksum_gate:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_misc && PWDATA[5] |=> GATE_ON[pbcg_pkg::MISC_BASE + 5])
	else $error("checksum gate not opened by a write of 1");

	a_flex_timer_gate:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_misc && !PWDATA[4] |=> !GATE_ON[pbcg_pkg::MISC_BASE + 4])
	else $error("flexible timer gate not closed by a write of 0");

	a_delay_block_hold:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		!wr_misc [*2] |-> $stable(GATE_ON[pbcg_pkg::MISC_BASE + 3]))
	else $error("delay block gate changed with no write");

	a_mod_timer_order:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_misc |=> GATE_ON[pbcg_pkg::MISC_BASE + 2 : pbcg_pkg::MISC_BASE] == $past(PWDATA[2:0]))
	else $error("modulo timer gates in the wrong order");

	a_comparator_gates:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_analog |=> GATE_ON[pbcg_pkg::ANALOG_BASE + 7 : pbcg_pkg::ANALOG_BASE + 5]
		== $past(PWDATA[7:5]))
	else $error("comparator gates do not follow bits 7 to 5");

	a_breakpoint_gate:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_analog |=> GATE_ON[pbcg_pkg::ANALOG_BASE + 4] == $past(PWDATA[4]))
	else $error("breakpoint gate does not follow bit 4");

	a_rtc_gate:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_analog && !PWDATA[3] |=> !RTC_CLK && !GATE_ON[pbcg_pkg::ANALOG_BASE + 3])
	else $error("real-time clock still clocked after clear");

	a_pulse_cnt_gate:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_analog |=> GATE_ON[pbcg_pkg::ANALOG_BASE + 2] == $past(PWDATA[2]))
	else $error("pulse counter gate does not follow bit 2");

	a_flash_gate:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_analog |=> GATE_ON[pbcg_pkg::ANALOG_BASE] == $past(PWDATA[0]))
	else $error("flash gate does not follow bit 0");

	a_reset_all_on:
	assert property (@(posedge SYS_CLK)
		!RESET_N |-> GATE_ON == IMPL_MASK && s_q.port_q == pbcg_pkg::PORT_GATES_RST)
	else $error("gates not all open during reset");

	a_unused_bits_zero:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		access_ph && !PWRITE
		|-> PRDATA[31:8] == 24'h00_0000
		&& (sel != pbcg_pkg::SEL_MISC || !PRDATA[7])
		&& (sel != pbcg_pkg::SEL_ANALOG || !PRDATA[1]))
	else $error("unused register bits read back nonzero");

	a_misc_bit7_zero:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_misc |=> !s_q.misc_q[7] && !GATE_ON[pbcg_pkg::MISC_BASE + 7])
	else $error("unused misc bit 7 took a write");

	a_read_answer:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		setup_ph && !PWRITE && sel == pbcg_pkg::SEL_ANALOG ##1 access_ph
		|-> PRDATA[7:0] == $past(s_q.analog_q) && !PSLVERR)
	else $error("analog gate register read back wrong");

	// a passed clock is still high just before the falling edge, a stopped one is low
	a_port_clk_levels:
	assert property (@(negedge SYS_CLK) disable iff (!RESET_N)
		{PORT_H_CLK, PORT_G_CLK, PORT_F_CLK, PORT_E0_CLK,
		PORT_D_CLK, PORT_C_CLK, PORT_B_CLK, PORT_A_CLK} == GATE_ON[7:0])
	else $error("a port clock does not match its gate");

	a_port_e_clk_pair:
	assert property (@(negedge SYS_CLK) disable iff (!RESET_N)
		PORT_E0_CLK == PORT_E1_CLK && PORT_E1_CLK == GATE_ON[pbcg_pkg::PORT_E_BIT])
	else $error("port e clocks differ from each other or from their gate");

	a_misc_clk_levels:
	assert property (@(negedge SYS_CLK) disable iff (!RESET_N)
		{PIN_SELECT_CLK, CHECKSUM_CLK, FLEX_TIMER_CLK, DELAY_BLOCK_CLK,
		MOD_TIMER_ONE_CLK, MOD_TIMER_TWO_CLK, MOD_TIMER_THREE_CLK}
		== GATE_ON[pbcg_pkg::MISC_BASE + 6 : pbcg_pkg::MISC_BASE])
	else $error("a misc peripheral clock does not match its gate");

	a_analog_clk_levels:
	assert property (@(negedge SYS_CLK) disable iff (!RESET_N)
		{CMP_TWO_CLK, CMP_ONE_CLK, CMP_ZERO_CLK, BREAKPOINT_CLK, RTC_CLK, PULSE_COUNTER_CLK}
		== GATE_ON[pbcg_pkg::ANALOG_BASE + 7 : pbcg_pkg::ANALOG_BASE + 2]
		&& FLASH_CLK == GATE_ON[pbcg_pkg::ANALOG_BASE])
	else $error("an analog or system clock does not match its gate");

	// the gate state trails the register only by the half cycle to the falling edge
	a_gate_state_match:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		GATE_ON == (gate_en & IMPL_MASK))
	else $error("gate state differs from the gate registers");

	a_gates_hold_idle:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		!wr_en |=> $stable(gate_en))
	else $error("gate registers changed with no accepted write");

	a_port_write_lands:
	assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_port |=> s_q.port_q == $past(PWDATA[7:0]))
	else $error("port gate register did not take the written byte");

endmodule

// ### test/pbcg_periph_model.sv
// model of the peripherals that receive the gated bus clocks
// assumes one clock per gate position, the second port e clock in the top bit
`timescale 1ns/10ps

module pbcg_periph_model (
	// gated clocks
	input  wire logic [24:0] clks,
	// control
	input  wire logic        clr,
	// status
	output logic      [24:0] running
);
	logic [3:0] cnt [25];

	for (genvar g = 0; g < 25; g++)
	begin : g_cnt
		// a stopped clock freezes the peripheral, so its state is stale on restart
		always_ff @(posedge clks[g] or posedge clr)
		begin
			if (clr)
				cnt[g] <= 4'h0;
			else if (cnt[g] != 4'hF)
				cnt[g] <= cnt[g] + 4'h1;
		end
		assign running[g] = (cnt[g] != 4'h0);
	end
endmodule

// ### test/pbcg_top_tb_top.sv
// self-checking bench: apb register accesses, gate status and gated clock activity
// assumes a zero-wait apb slave and peripheral models that count clock edges
`timescale 1ns/10ps

module pbcg_top_tb_top;
	logic                         sys_clk;
	logic                         reset_n;
	logic                         psel;
	logic                         penable;
	logic                         pwrite;
	logic [pbcg_pkg::ADDR_W-1:0]  paddr;
	logic [31:0]                  pwdata;
	logic [31:0]                  prdata;
	logic [3:0]                   pstrb;
	logic                         pready;
	logic                         pslverr;
	logic [23:0]                  gate_on;
	logic [24:0]                  clks;
	logic [24:0]                  running;
	logic                         clr;
	logic [7:0]                   exp_r [3];
	logic [7:0]                   masks [3];
	logic [pbcg_pkg::ADDR_W-1:0]  offs [3];
	logic [31:0]                  rd;
	logic                         er;
	int                           fails;
	int                           n_checks;

	// unused gate positions carry no clock
	assign clks[15] = 1'h0;
	assign clks[17] = 1'h0;

	pbcg_top i_dut (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PORT_A_CLK(clks[0]), .PORT_B_CLK(clks[1]), .PORT_C_CLK(clks[2]),
		.PORT_D_CLK(clks[3]), .PORT_E0_CLK(clks[4]), .PORT_E1_CLK(clks[24]),
		.PORT_F_CLK(clks[5]), .PORT_G_CLK(clks[6]), .PORT_H_CLK(clks[7]),
		.MOD_TIMER_THREE_CLK(clks[8]), .MOD_TIMER_TWO_CLK(clks[9]),
		.MOD_TIMER_ONE_CLK(clks[10]), .DELAY_BLOCK_CLK(clks[11]),
		.FLEX_TIMER_CLK(clks[12]), .CHECKSUM_CLK(clks[13]), .PIN_SELECT_CLK(clks[14]),
		.FLASH_CLK(clks[16]), .PULSE_COUNTER_CLK(clks[18]), .RTC_CLK(clks[19]),
		.BREAKPOINT_CLK(clks[20]), .CMP_ZERO_CLK(clks[21]), .CMP_ONE_CLK(clks[22]),
		.CMP_TWO_CLK(clks[23]), .GATE_ON(gate_on)
	);

	pbcg_periph_model i_periph (
		.clks(clks),
		.clr(clr),
		.running(running)
	);

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask

	task automatic check_flag(input string name, input logic exp, input logic got);
		n_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %b seen %b", name, exp, got);
			fails++;
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rdat, output logic err);
		int i;
		@(posedge sys_clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge sys_clk);
		penable <= 1'h1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge sys_clk);
			if (pready === 1'h1)
				break;
		end
		if (i == 16)
		begin
			fails++;
			conclude();
		end
		rdat = prdata;
		err  = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input int k, input logic [31:0] d);
		apb(1'h1, offs[k], d, 4'h1, rd, er);
		check_flag("write error", 1'h0, er);
	endtask

	task automatic do_reset;
		@(posedge sys_clk);
		reset_n <= 1'h0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'h1;
		exp_r = masks;
	endtask

	// registers, gate status and clock activity against the expected gate bits
	task automatic check_regs;
		for (int k = 0; k < 3; k++)
		begin
			apb(1'h0, offs[k], 32'h0000_0000, 4'h0, rd, er);
			check_val("register", {24'h00_0000, exp_r[k]}, rd);
			check_flag("read error", 1'h0, er);
		end
		repeat (2) @(posedge sys_clk);
		check_val("gate_on", {8'h00, exp_r[2], exp_r[1], exp_r[0]}, {8'h00, gate_on});
		clr <= 1'h1;
		@(posedge sys_clk);
		clr <= 1'h0;
		repeat (4) @(posedge sys_clk);
		check_val("clocks", {7'h00, exp_r[0][4], exp_r[2], exp_r[1], exp_r[0]},
			{7'h00, running});
	endtask

	initial
	begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end

	// watchdog against a hung sequence
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		conclude();
	end

	initial
	begin
		// high at first, so the reset below gives every async flop of the dut a clean falling edge
		reset_n  = 1'h1;
		psel     = 1'h0;
		penable  = 1'h0;
		pwrite   = 1'h0;
		paddr    = 12'h000;
		pwdata   = 32'h0000_0000;
		pstrb    = 4'h0;
		clr      = 1'h0;
		fails    = 0;
		n_checks = 0;
		offs  = '{pbcg_pkg::PORT_GATES_OFS, pbcg_pkg::MISC_GATES_OFS, pbcg_pkg::ANALOG_GATES_OFS};
		masks = '{pbcg_pkg::PORT_GATES_MASK, pbcg_pkg::MISC_GATES_MASK,
			pbcg_pkg::ANALOG_GATES_MASK};
		do_reset();
		check_regs();
		// one gate stopped at a time; peripheral taken as idle first
		for (int k = 0; k < 3; k++)
			for (int b = 0; b < 8; b++)
				if (masks[k][b])
				begin
					exp_r[k] = masks[k] & ~(8'h01 << b);
					wr(k, {24'h00_0000, exp_r[k]});
					check_regs();
					exp_r[k] = masks[k];
					wr(k, {24'h00_0000, exp_r[k]});
				end
		// every bit written as one: unused and upper bits stay zero
		for (int k = 0; k < 3; k++)
			wr(k, 32'hFFFF_FFFF);
		check_regs();
		// all gates stopped
		for (int k = 0; k < 3; k++)
		begin
			wr(k, 32'h0000_0000);
			exp_r[k] = 8'h00;
		end
		check_regs();
		// byte lane 0 not strobed: no change
		apb(1'h1, offs[0], 32'h0000_00FF, 4'hE, rd, er);
		check_flag("strobe error", 1'h0, er);
		// unmapped address refused on write and read
		apb(1'h1, 12'h00C, 32'h0000_00FF, 4'h1, rd, er);
		check_flag("unmapped write error", 1'h1, er);
		apb(1'h0, 12'h00C, 32'h0000_0000, 4'h0, rd, er);
		check_flag("unmapped read error", 1'h1, er);
		check_val("unmapped data", 32'h0000_0000, rd);
		check_regs();
		// analog and system clocks restored, port and misc clocks stay stopped; peripherals reinitialised afterwards
		wr(2, 32'h0000_00FD);
		exp_r[2] = 8'hFD;
		check_regs();
		// reset in mid-run brings every gate back
		do_reset();
		check_regs();
		conclude();
	end
endmodule
